// ---- src/agp_target_pkg.sv ----
// Shared constants and carrier types for the graphics port target block
package agp_target_pkg;

	// ********************************************************************
	// Command codes
	// ********************************************************************
	localparam logic [3:0] CMD_RD_LP     = 4'h0;
	localparam logic [3:0] CMD_RD_HP     = 4'h1;
	localparam logic [3:0] CMD_ISO_RD    = 4'h3;
	localparam logic [3:0] CMD_WR_LP     = 4'h4;
	localparam logic [3:0] CMD_WR_HP     = 4'h5;
	localparam logic [3:0] CMD_ISO_WR_UF = 4'h6;
	localparam logic [3:0] CMD_ISO_WR_F  = 4'h7;
	localparam logic [3:0] CMD_LRD_LP    = 4'h8;
	localparam logic [3:0] CMD_LRD_HP    = 4'h9;
	localparam logic [3:0] CMD_FLUSH     = 4'hA;
	localparam logic [3:0] CMD_FENCE     = 4'hC;
	localparam logic [3:0] CMD_ISO_ALIGN = 4'hE;

	// ********************************************************************
	// Status and command field positions
	// ********************************************************************
	localparam int STAT_MODE3_BIT  = 3;
	localparam int STAT_RATE8_BIT  = 1;
	localparam int CMD_RATE8_BIT   = 1;
	localparam logic [7:0] STAT_RST = 8'h00;

	// ********************************************************************
	// Timing and transfer sizes
	// ********************************************************************
	localparam int LAT_PCI66_CLKS = 16;
	localparam int LAT_STD_CLKS   = 8;
	localparam int BLOCK_CLKS     = 4;
	localparam int BYTES_8X       = 32;
	localparam int BYTES_4X       = 16;
	localparam int BYTES_1X       = 4;
	localparam int BLOCK_BYTES_8X = BLOCK_CLKS * BYTES_8X;

	// ********************************************************************
	// Decoded command kinds
	// ********************************************************************
	typedef enum logic [2:0] {
		KIND_NONE  = 3'h0,
		KIND_READ  = 3'h1,
		KIND_WRITE = 3'h2,
		KIND_FLUSH = 3'h3,
		KIND_FENCE = 3'h4,
		KIND_BAD   = 3'h5
	} cmd_kind_t;

	typedef struct packed {
		cmd_kind_t  kind;
		logic       high_prio;
		logic       long_read;
	} cmd_dec_t;

	// Request arriving from the port front end
	typedef struct packed {
		logic        valid;
		logic [3:0]  code;
		logic        pipelined;   // From pipelined or sideband request path
		logic [31:0] addr;
		logic        to_memory;   // Address falls in main memory
	} agp_req_t;

	// Request handed to memory
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        high_prio;
		logic        long_read;
		logic        check_wbuf;
		logic        snoop;
		logic [31:0] addr;
	} mem_req_t;

endpackage

// ---- src/agp_cmd_decode.sv ----
// Command code decoder for both protocol sets of the graphics port
module agp_cmd_decode (
	// Command in
	input  wire logic [3:0]                 i_code,
	input  wire logic                       i_mode3,
	// Decoded command out
	output agp_target_pkg::cmd_dec_t        o_dec
);

	// Decode per active protocol set
	always_comb begin
		o_dec = '{kind: agp_target_pkg::KIND_BAD, high_prio: 1'b0,
			long_read: 1'b0};
		if (i_mode3) begin
			case (i_code)
				agp_target_pkg::CMD_RD_LP: o_dec.kind = agp_target_pkg::KIND_READ;
				agp_target_pkg::CMD_WR_LP: o_dec.kind = agp_target_pkg::KIND_WRITE;
				agp_target_pkg::CMD_FLUSH: o_dec.kind = agp_target_pkg::KIND_FLUSH;
				agp_target_pkg::CMD_FENCE: o_dec.kind = agp_target_pkg::KIND_FENCE;
				// Isochronous codes fall out as unsupported
				agp_target_pkg::CMD_ISO_RD,
				agp_target_pkg::CMD_ISO_WR_UF,
				agp_target_pkg::CMD_ISO_WR_F,
				agp_target_pkg::CMD_ISO_ALIGN: o_dec.kind = agp_target_pkg::KIND_BAD;
				default: o_dec.kind = agp_target_pkg::KIND_BAD;
			endcase
		end else begin
			case (i_code)
				agp_target_pkg::CMD_RD_LP: o_dec.kind = agp_target_pkg::KIND_READ;
				agp_target_pkg::CMD_RD_HP: begin
					o_dec.kind      = agp_target_pkg::KIND_READ;
					o_dec.high_prio = 1'b1;
				end
				agp_target_pkg::CMD_WR_LP: o_dec.kind = agp_target_pkg::KIND_WRITE;
				agp_target_pkg::CMD_WR_HP: begin
					o_dec.kind      = agp_target_pkg::KIND_WRITE;
					o_dec.high_prio = 1'b1;
				end
				agp_target_pkg::CMD_LRD_LP: begin
					o_dec.kind      = agp_target_pkg::KIND_READ;
					o_dec.long_read = 1'b1;
				end
				agp_target_pkg::CMD_LRD_HP: begin
					o_dec.kind      = agp_target_pkg::KIND_READ;
					o_dec.long_read = 1'b1;
					o_dec.high_prio = 1'b1;
				end
				agp_target_pkg::CMD_FLUSH: o_dec.kind = agp_target_pkg::KIND_FLUSH;
				agp_target_pkg::CMD_FENCE: o_dec.kind = agp_target_pkg::KIND_FENCE;
				default: o_dec.kind = agp_target_pkg::KIND_BAD;
			endcase
		end
	end

endmodule

// ---- src/agp_target_interface.sv ----
// Graphics port target: command routing, rate, fast writes, PCI-66 mode

module agp_target_interface #(
	parameter int ADDR_W = 32
) (
	// Clock and reset
	input  wire logic                    i_mclk,
	input  wire logic                    i_rst_b,
	// Straps and configuration
	input  wire logic                    i_pwrok,
	input  wire logic                    i_mode3_detect,
	input  wire logic [7:0]              i_cmd_reg,
	input  wire logic                    i_pci66_mode,
	// Enhanced and PCI requests from the card
	input  agp_target_pkg::agp_req_t     i_agp_req,
	input  agp_target_pkg::agp_req_t     i_pci_req,
	input  wire logic                    i_pci_req_grant,
	input  wire logic                    i_pci_data_rdy,
	// Hub side outbound traffic
	input  wire logic                    i_hub_wr_valid,
	input  wire logic [ADDR_W-1:0]       i_hub_wr_addr,
	input  wire logic                    i_hub_wr_is_mem,
	// Flow control
	input  wire logic                    i_throttle_req,
	// Outputs
	output agp_target_pkg::mem_req_t     o_mem_req,
	output logic [7:0]                   o_status,
	output logic [5:0]                   o_bytes_per_clk,
	output logic                         o_rate_err,
	output logic                         o_bad_cmd,
	output logic                         o_flush,
	output logic                         o_fence,
	output logic                         o_fw_start,
	output logic                         o_fw_agp_data,
	output logic                         o_throttled,
	output logic                         o_lat_timeout,
	output logic                         o_pci_gnt
);

	// ********************************************************************
	// Synchronisers for pin inputs
	// ********************************************************************
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;

	// Only the second stage feeds logic
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {i_pwrok, i_mode3_detect, i_throttle_req};
			sync2_q <= sync1_q;
		end
	end

	logic pwrok_s;
	logic detect_s;
	logic throttle_s;
	assign pwrok_s    = sync2_q[2];
	assign detect_s   = sync2_q[1];
	assign throttle_s = sync2_q[0];

	// ********************************************************************
	// Strap capture and status
	// ********************************************************************
	logic       pwrok_q, pwrok_d;
	logic       strap_done_q, strap_done_d;
	logic [7:0] status_q, status_d;
	logic       rate8_q, rate8_d;
	logic       rate_set_q, rate_set_d;

	// Mode caught once at the rising power-good, never relatched
	always_comb begin
		pwrok_d      = pwrok_s;
		strap_done_d = strap_done_q;
		status_d     = status_q;
		rate8_d      = rate8_q;
		rate_set_d   = rate_set_q;
		if (pwrok_s && !pwrok_q && !strap_done_q) begin
			strap_done_d = 1'b1;
			status_d[agp_target_pkg::STAT_MODE3_BIT] = detect_s;
			status_d[agp_target_pkg::STAT_RATE8_BIT] = detect_s;
		end
		// Rate taken once; later changes are ignored
		if (strap_done_q && !rate_set_q) begin
			rate_set_d = 1'b1;
			rate8_d    = i_cmd_reg[agp_target_pkg::CMD_RATE8_BIT];
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwrok_q      <= 1'b0;
			strap_done_q <= 1'b0;
			status_q     <= agp_target_pkg::STAT_RST;
			rate8_q      <= 1'b0;
			rate_set_q   <= 1'b0;
		end else begin
			pwrok_q      <= pwrok_d;
			strap_done_q <= strap_done_d;
			status_q     <= status_d;
			rate8_q      <= rate8_d;
			rate_set_q   <= rate_set_d;
		end
	end

	logic mode3;
	assign mode3 = status_q[agp_target_pkg::STAT_MODE3_BIT];

	// ********************************************************************
	// Command decode
	// ********************************************************************
	agp_target_pkg::cmd_dec_t dec;

	agp_cmd_decode u_dec (
		.i_code  (i_agp_req.code),
		.i_mode3 (mode3),
		.o_dec   (dec)
	);

	// ********************************************************************
	// Data rate and throttle block counter
	// ********************************************************************
	logic [5:0] bpc_q, bpc_d;
	logic       rate_err_q, rate_err_d;
	logic [1:0] blk_q, blk_d;
	logic       thr_q, thr_d;

	// 8X only legal in 3.0 mode; 2X never offered
	always_comb begin
		bpc_d      = bpc_q;
		rate_err_d = rate_err_q;
		if (rate_set_q) begin
			if (rate8_q && mode3) begin
				bpc_d = 6'(agp_target_pkg::BYTES_8X);
			end else if (mode3 || !i_pci66_mode) begin
				bpc_d = 6'(agp_target_pkg::BYTES_4X);
			end else begin
				bpc_d = 6'(agp_target_pkg::BYTES_1X);
			end
			rate_err_d = rate8_q && !mode3;
		end
		// Throttle honoured only as a block closes
		blk_d = blk_q + 2'h1;
		thr_d = thr_q;
		if (blk_q == 2'(agp_target_pkg::BLOCK_CLKS - 1)) begin
			thr_d = throttle_s;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bpc_q      <= 6'h00;
			rate_err_q <= 1'b0;
			blk_q      <= 2'h0;
			thr_q      <= 1'b0;
		end else begin
			bpc_q      <= bpc_d;
			rate_err_q <= rate_err_d;
			blk_q      <= blk_d;
			thr_q      <= thr_d;
		end
	end

	// ********************************************************************
	// Request routing
	// ********************************************************************
	agp_target_pkg::mem_req_t mreq_q, mreq_d;
	logic bad_q, bad_d;
	logic flush_q, flush_d;
	logic fence_q, fence_d;
	logic gnt_q, gnt_d;
	logic pci_turn_q, pci_turn_d;

	// Both request kinds served, alternating when both wait
	always_comb begin
		mreq_d     = '0;
		bad_d      = 1'b0;
		flush_d    = 1'b0;
		fence_d    = 1'b0;
		pci_turn_d = pci_turn_q;
		// Single agent: grant follows its own request in PCI-66 mode only, else held low
		gnt_d = i_pci66_mode ? i_pci_req.valid : 1'b0;
		if (!thr_q) begin
			if (i_agp_req.valid && (!i_pci_req.valid || !pci_turn_q)) begin
				pci_turn_d = 1'b1;
				case (dec.kind)
					agp_target_pkg::KIND_READ,
					agp_target_pkg::KIND_WRITE: begin
						if (i_agp_req.to_memory) begin
							mreq_d.valid = 1'b1;
							mreq_d.write =
								dec.kind == agp_target_pkg::KIND_WRITE;
							// No ordering hazard logic on priority
							mreq_d.high_prio = dec.high_prio;
							mreq_d.long_read = dec.long_read;
							mreq_d.check_wbuf = i_agp_req.pipelined;
							mreq_d.addr = i_agp_req.addr;
						end else begin
							bad_d = 1'b1;
						end
					end
					agp_target_pkg::KIND_FLUSH: flush_d = 1'b1;
					agp_target_pkg::KIND_FENCE: fence_d = 1'b1;
					default: bad_d = 1'b1;
				endcase
			end else if (i_pci_req.valid && i_pci_req.to_memory) begin
				pci_turn_d = 1'b0;
				mreq_d.valid = 1'b1;
				mreq_d.write = i_pci_req.code[0];
				mreq_d.snoop = 1'b1;
				mreq_d.addr  = i_pci_req.addr;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mreq_q     <= '0;
			bad_q      <= 1'b0;
			flush_q    <= 1'b0;
			fence_q    <= 1'b0;
			gnt_q      <= 1'b0;
			pci_turn_q <= 1'b0;
		end else begin
			mreq_q     <= mreq_d;
			bad_q      <= bad_d;
			flush_q    <= flush_d;
			fence_q    <= fence_d;
			gnt_q      <= gnt_d;
			pci_turn_q <= pci_turn_d;
		end
	end

	// ********************************************************************
	// Outbound fast writes and latency timer
	// ********************************************************************
	logic       fw_q, fw_d;
	logic       fw_agp_q, fw_agp_d;
	logic [4:0] lat_q, lat_d;
	logic       lat_to_q, lat_to_d;
	logic [4:0] lat_lim;

	// Limit doubles in PCI-66 use
	assign lat_lim = i_pci66_mode ? 5'(agp_target_pkg::LAT_PCI66_CLKS)
		: 5'(agp_target_pkg::LAT_STD_CLKS);

	// Device initiates plain PCI writes only; no lock, no error pins
	always_comb begin
		fw_d     = 1'b0;
		fw_agp_d = 1'b0;
		if (i_hub_wr_valid && i_hub_wr_is_mem && !thr_q) begin
			fw_d     = 1'b1;
			fw_agp_d = bpc_q != 6'(agp_target_pkg::BYTES_1X) &&
				bpc_q != 6'h00;
		end
		lat_d    = lat_q;
		lat_to_d = 1'b0;
		if (!i_pci_req_grant || i_pci_data_rdy) begin
			lat_d = 5'h00;
		end else if (lat_q == lat_lim - 5'h01) begin
			lat_d    = 5'h00;
			lat_to_d = 1'b1;
		end else begin
			lat_d = lat_q + 5'h01;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fw_q     <= 1'b0;
			fw_agp_q <= 1'b0;
			lat_q    <= 5'h00;
			lat_to_q <= 1'b0;
		end else begin
			fw_q     <= fw_d;
			fw_agp_q <= fw_agp_d;
			lat_q    <= lat_d;
			lat_to_q <= lat_to_d;
		end
	end

	// ********************************************************************
	// Outputs, all straight from flops
	// ********************************************************************
	assign o_mem_req       = mreq_q;
	assign o_status        = status_q;
	assign o_bytes_per_clk = bpc_q;
	assign o_rate_err      = rate_err_q;
	assign o_bad_cmd       = bad_q;
	assign o_flush         = flush_q;
	assign o_fence         = fence_q;
	assign o_fw_start      = fw_q;
	assign o_fw_agp_data   = fw_agp_q;
	assign o_throttled     = thr_q;
	assign o_lat_timeout   = lat_to_q;
	assign o_pci_gnt       = gnt_q;

endmodule

// ---- testbench/agp_target_interface_assertions.sv ----
// Concurrent checks on the graphics port target ports
module agp_target_checker (
	// Clock, reset, configuration and hub writes
	input  wire logic			i_mclk,
	input  wire logic			i_rst_b,
	input  wire logic			i_pci66_mode,
	input  wire logic			i_hub_wr_valid,
	input  wire logic			i_hub_wr_is_mem,
	// Requests and answers
	input  agp_target_pkg::agp_req_t	i_agp_req,
	input  agp_target_pkg::agp_req_t	i_pci_req,
	input  agp_target_pkg::mem_req_t	o_mem_req,
	input  wire logic [7:0]		o_status,
	input  wire logic [5:0]		o_bytes_per_clk,
	input  wire logic			o_bad_cmd,
	input  wire logic			o_flush,
	input  wire logic			o_fence,
	input  wire logic			o_fw_start,
	input  wire logic			o_throttled,
	input  wire logic			o_pci_gnt
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// Port checks
	// ****************************************************************
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	// Lone enhanced request taken at this edge, no arbitration in play
	logic	solo;
	assign solo = i_agp_req.valid && !i_pci_req.valid && !o_throttled;

	chk_resv_no_mem: assert property (
		o_bad_cmd |-> !o_mem_req.valid)
		else $error("refused command also went to memory");
	chk_nonmem_refused: assert property (
		solo && !i_agp_req.to_memory && i_agp_req.code == 4'h0
		|=> o_bad_cmd && !o_mem_req.valid)
		else $error("enhanced read off memory not refused");
	chk_iso_refused: assert property (
		solo && o_status[3]
		&& i_agp_req.code inside {4'h3, 4'h6, 4'h7, 4'hE}
		|=> o_bad_cmd && !o_mem_req.valid)
		else $error("isochronous code not refused");
	chk_flush_pulse: assert property (
		solo && i_agp_req.code == 4'hA |=> o_flush && !o_fence)
		else $error("flush code gave no flush pulse");
	chk_fence_pulse: assert property (
		solo && i_agp_req.code == 4'hC |=> o_fence && !o_flush)
		else $error("fence code gave no fence pulse");
	chk_wbuf_seen: assert property (
		solo && i_agp_req.pipelined && i_agp_req.to_memory
		&& i_agp_req.code == 4'h4
		|=> o_mem_req.valid && o_mem_req.write && o_mem_req.check_wbuf)
		else $error("pipelined write skipped write buffer check");
	chk_gnt_follows: assert property (
		i_pci66_mode |=> o_pci_gnt == $past(i_pci_req.valid))
		else $error("grant does not follow the single agent");
	chk_block_hold: assert property (
		$changed(o_throttled) |=> $stable(o_throttled)[*3])
		else $error("throttle changed inside a block");
	chk_rate_legal: assert property (
		o_bytes_per_clk != 6'h08
		&& !(!o_status[3] && o_bytes_per_clk == 6'h20))
		else $error("illegal data rate in use");
	chk_status_bits: assert property (
		o_status[1] == o_status[3] && (o_status & 8'hF5) == 8'h00)
		else $error("status capability bits inconsistent");
	chk_fw_start: assert property (
		i_hub_wr_valid && i_hub_wr_is_mem && !o_throttled
		|=> o_fw_start)
		else $error("hub memory write started no fast write");
	chk_fw_memonly: assert property (
		i_hub_wr_valid && !i_hub_wr_is_mem |=> !o_fw_start)
		else $error("non-memory hub traffic was forwarded");
endmodule

bind agp_target_interface agp_target_checker u_agp_target_checker (
	.i_mclk, .i_rst_b, .i_pci66_mode, .i_hub_wr_valid, .i_hub_wr_is_mem,
	.i_agp_req, .i_pci_req, .o_mem_req, .o_status, .o_bytes_per_clk,
	.o_bad_cmd, .o_flush, .o_fence, .o_fw_start, .o_throttled, .o_pci_gnt
);

// ---- testbench/agp_card_model.sv ----
// Behavioural graphics card issuing enhanced and PCI requests
module agp_card_model (
	// Clock
	input  wire logic			i_mclk,
	// Requests toward the target
	output agp_target_pkg::agp_req_t	o_agp_req,
	output agp_target_pkg::agp_req_t	o_pci_req
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// Request issue
	// ****************************************************************
	// Single master, no lock line exists on this card
	initial begin
		o_agp_req = '0;
		o_pci_req = '0;
	end

	// One request held for exactly one edge; idle lines then flip so
	// a stale value never looks valid. Isochronous codes only on demand
	task automatic send(input logic pci, input logic [3:0] code,
		input logic mem, input logic pipe);
		agp_target_pkg::agp_req_t r;
		agp_target_pkg::agp_req_t idle;
		r = '{1'b1, code, pipe, 32'h0000_1000 + code, mem};
		idle = ~r;
		idle.valid = 1'b0;
		@(posedge i_mclk);
		if (pci)
			o_pci_req <= r;
		else
			o_agp_req <= r;
		@(posedge i_mclk);
		if (pci)
			o_pci_req <= idle;
		else
			o_agp_req <= idle;
	endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the graphics port target block
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic				i_mclk, i_rst_b, i_pwrok, i_mode3_detect;
	logic [7:0]			i_cmd_reg, o_status;
	logic				i_pci66_mode, i_pci_req_grant, i_pci_data_rdy;
	logic				i_hub_wr_valid, i_hub_wr_is_mem, i_throttle_req;
	logic [31:0]		i_hub_wr_addr;
	logic [5:0]			o_bytes_per_clk;
	logic				o_rate_err, o_bad_cmd, o_flush, o_fence;
	logic				o_fw_start, o_fw_agp_data, o_throttled;
	logic				o_lat_timeout, o_pci_gnt;
	agp_target_pkg::agp_req_t	agp_req, pci_req;
	agp_target_pkg::mem_req_t	o_mem_req;
	int					error_cnt, num_checks;

	// ****************************************************************
	// Clock, design and card
	// ****************************************************************
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end

	agp_target_interface u_agp_target_interface (
		.i_mclk, .i_rst_b, .i_pwrok, .i_mode3_detect, .i_cmd_reg,
		.i_pci66_mode, .i_agp_req(agp_req), .i_pci_req(pci_req),
		.i_pci_req_grant, .i_pci_data_rdy, .i_hub_wr_valid, .i_hub_wr_addr,
		.i_hub_wr_is_mem, .i_throttle_req, .o_mem_req, .o_status,
		.o_bytes_per_clk, .o_rate_err, .o_bad_cmd, .o_flush, .o_fence,
		.o_fw_start, .o_fw_agp_data, .o_throttled, .o_lat_timeout,
		.o_pci_gnt
	);

	agp_card_model u_agp_card_model (
		.i_mclk, .o_agp_req(agp_req), .o_pci_req(pci_req)
	);

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Bounded wait on throttle (which=1) or latency timeout (which=0)
	task automatic wait_for(input string nm, input int which,
		input logic v, output int n);
		n = 0;
		while ((which ? o_throttled : o_lat_timeout) !== v && n < 30) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		check(nm, which ? o_throttled : o_lat_timeout, v);
		if (n >= 30)
			print_verdict();
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Reset, fresh strap latch, then status and rate
	task automatic t_cfg(input logic m3, input logic [7:0] cr,
		input logic p66, input logic [7:0] st, input logic [5:0] by,
		input logic er);
		@(posedge i_mclk);
		i_rst_b <= 1'b0;
		i_pwrok <= 1'b0;
		i_mode3_detect <= m3;
		i_cmd_reg <= cr;
		i_pci66_mode <= p66;
		repeat (2) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		@(posedge i_mclk);
		i_pwrok <= 1'b1;
		repeat (8) @(posedge i_mclk);
		#1;
		check("status", o_status, st);
		check("bytes", o_bytes_per_clk, by);
		check("rate_err", o_rate_err, er);
	endtask

	// Every code of the active mode, pipelined on bit 2
	task automatic t_codes(input logic m3);
		logic [7:0]	e, s;
		logic [3:0]	c;
		logic		rd, wr;
		logic [31:0]	a;
		for (int i = 0; i < 16; i++) begin
			c = i[3:0];
			rd = c == 4'h0 || (!m3 && c inside {4'h1, 4'h8, 4'h9});
			wr = c == 4'h4 || (!m3 && c == 4'h5);
			e = {rd | wr, wr, !m3 & c[0] & (rd | wr), !m3 & c[3] & rd,
				c == 4'hA, c == 4'hC, !(rd | wr | c == 4'hA | c == 4'hC),
				(rd | wr) & c[2]};
			u_agp_card_model.send(1'b0, c, 1'b1, c[2]);
			#1;
			s = {o_mem_req.valid, o_mem_req.write, o_mem_req.high_prio,
				o_mem_req.long_read, o_flush, o_fence, o_bad_cmd,
				o_mem_req.check_wbuf};
			check("decode", s, e);
			// Address passes only with a memory access, else all zero
			a = (rd | wr) ? 32'h0000_1000 + 32'(c) : 32'h0000_0000;
			check("addr", o_mem_req.addr, a);
			check("snoop", o_mem_req.snoop, 1'b0);
		end
	endtask

	// Off-memory enhanced read, then a PCI memory write right after
	task automatic t_route();
		u_agp_card_model.send(1'b0, 4'h0, 1'b0, 1'b0);
		#1;
		check("nonmem", {o_bad_cmd, o_mem_req.valid}, 2'b10);
		u_agp_card_model.send(1'b1, 4'h7, 1'b1, 1'b0);
		#1;
		check("pci_wr", {o_mem_req.valid, o_mem_req.write,
			o_mem_req.snoop, o_pci_gnt}, {3'b111, i_pci66_mode});
	endtask

	// Hub memory write starts a fast write, other hub traffic does not
	task automatic t_fw(input logic ag);
		for (int i = 1; i >= 0; i--) begin
			@(posedge i_mclk);
			i_hub_wr_valid <= 1'b1;
			i_hub_wr_is_mem <= i[0];
			@(posedge i_mclk);
			i_hub_wr_valid <= 1'b0;
			#1;
			check("fw", {o_fw_start, o_fw_agp_data & i[0]},
				{i[0], ag & i[0]});
		end
	endtask

	// Grant held without data until the latency timer expires
	task automatic t_lat(input int lim);
		int	n;
		@(posedge i_mclk);
		i_pci_req_grant <= 1'b1;
		i_pci_data_rdy <= 1'b0;
		wait_for("lat_timeout", 0, 1'b1, n);
		// Pulse seen just after the limit-th stalled edge
		check("lat_cycles", n, lim);
		@(posedge i_mclk);
		i_pci_req_grant <= 1'b0;
		i_pci_data_rdy <= 1'b1;
	endtask

	// Throttle on, request dropped, throttle off at a block edge
	task automatic t_throttle();
		int	n;
		@(posedge i_mclk);
		i_throttle_req <= 1'b1;
		wait_for("throttle_on", 1, 1'b1, n);
		u_agp_card_model.send(1'b0, 4'h0, 1'b1, 1'b0);
		#1;
		check("dropped", o_mem_req.valid, 1'b0);
		@(posedge i_mclk);
		i_throttle_req <= 1'b0;
		wait_for("throttle_off", 1, 1'b0, n);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		i_rst_b = 1'b0;
		i_pwrok = 1'b0;
		i_mode3_detect = 1'b0;
		i_cmd_reg = 8'h00;
		i_pci66_mode = 1'b0;
		i_pci_req_grant = 1'b0;
		i_pci_data_rdy = 1'b1;
		i_hub_wr_valid = 1'b0;
		i_hub_wr_is_mem = 1'b0;
		i_hub_wr_addr = 32'h0000_2000;
		i_throttle_req = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		t_cfg(1'b0, 8'h00, 1'b0, 8'h00, 6'h10, 1'b0);
		t_codes(1'b0);
		t_route();
		t_fw(1'b1);
		t_lat(8);
		t_throttle();
		t_cfg(1'b0, 8'h02, 1'b0, 8'h00, 6'h10, 1'b1);
		t_cfg(1'b1, 8'h00, 1'b0, 8'h0A, 6'h10, 1'b0);
		t_cfg(1'b1, 8'h02, 1'b0, 8'h0A, 6'h20, 1'b0);
		t_codes(1'b1);
		t_fw(1'b1);
		t_cfg(1'b0, 8'h00, 1'b1, 8'h00, 6'h04, 1'b0);
		t_route();
		t_fw(1'b0);
		t_lat(16);
		print_verdict();
	end
endmodule
